/* fcs_config_status.sv */
// configuration register and second status register of a serial flash
`timescale 1ns/1ps
`include "fcs_regs.svh"

// Operation
// - two-bit latency code in config bits 7:6
// - config bit 5 anchors protection at bottom
// - protect bits block writes; bit 3 volatility
// - config bit 2 puts parameter sectors top
// - parameter bit ignored on uniform-only parts
// - config bit 1 selects quad I/O
// - freeze bit 0 locks protection and OTP
// - status2 bit 7 selects 256k erase
// - status2 bit 5 makes line 3 reset
// - status2 bit 1 shows erase suspended
// - status2 bit 0 shows program suspended
// - reserved status2 bits read zero
module fcs_config_status (
    // clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    // register port
    input  wire logic [1:0]           i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    // array controller state
    input  wire logic                 i_erase_susp,
    input  wire logic                 i_prog_susp,
    input  wire logic                 i_uniform_part,
    // configuration outputs
    output logic      [1:0]           o_latency_code,
    output logic                      o_protect_from_bottom,
    output logic      [2:0]           o_block_protect_bits,
    output logic                      o_protect_bits_volatile,
    output logic                      o_param_sectors_top,
    output fcs_pkg::fcs_io_mode_t     o_io_mode,
    output logic                      o_frozen,
    output logic      [8:0]           o_erase_size_kb,
    output logic                      o_page_wrap_size,
    output fcs_pkg::fcs_line3_t       o_line3_function
);
    import fcs_pkg::*;

    // non-volatile and volatile state
    logic [1:0] latency_reg;
    logic [1:0] latency_next;
    logic       quad_reg;
    logic       quad_next;
    logic       freeze_reg;
    logic       freeze_next;
    logic [2:0] bp_reg;
    logic [2:0] bp_next;
    logic       strap_done_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // output flops
    logic [1:0]   latency_out_reg;
    logic         prot_bot_out_reg;
    logic [2:0]   bp_out_reg;
    logic         bp_vol_out_reg;
    logic         parm_top_out_reg;
    fcs_io_mode_t io_mode_reg;
    logic         frozen_out_reg;
    logic [8:0]   erase_kb_reg;
    logic         wrap_out_reg;
    fcs_line3_t   line3_reg;

    // decode
    wire wr_cfg   = i_wr && (i_addr == `FCS_ADDR_CFG);
    wire wr_sts2  = i_wr && (i_addr == `FCS_ADDR_STS2);
    wire wr_bprot = i_wr && (i_addr == `FCS_ADDR_BPROT);

    // otp fields and suspend flags
    wire prot_bot;
    wire bp_vol;
    wire parm_top_raw;
    wire rsvd4;
    wire big_erase;
    wire page_wrap;
    wire line3_rst;
    wire erase_susp;
    wire prog_susp;

    fcs_otp_bit u_prot_bot (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_cfg),
        .i_data  (i_wdata[`FCS_CFG_PROT_BOT]),
        .i_lock  (freeze_reg),
        .o_value (prot_bot)
    );

    fcs_otp_bit u_bp_vol (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_cfg),
        .i_data  (i_wdata[`FCS_CFG_BP_VOL]),
        .i_lock  (freeze_reg),
        .o_value (bp_vol)
    );

    fcs_otp_bit u_parm_top (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_cfg),
        .i_data  (i_wdata[`FCS_CFG_PARM_TOP]),
        .i_lock  (freeze_reg),
        .o_value (parm_top_raw)
    );

    fcs_otp_bit u_rsvd4 (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_cfg),
        .i_data  (i_wdata[`FCS_CFG_RSVD4]),
        .i_lock  (freeze_reg),
        .o_value (rsvd4)
    );

    fcs_otp_bit u_big_erase (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_sts2),
        .i_data  (i_wdata[`FCS_STS2_BIG_ERASE]),
        .i_lock  (freeze_reg),
        .o_value (big_erase)
    );

    fcs_otp_bit u_page_wrap (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_sts2),
        .i_data  (i_wdata[`FCS_STS2_PAGE_WRAP]),
        .i_lock  (freeze_reg),
        .o_value (page_wrap)
    );

    fcs_otp_bit u_line3 (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_sts2),
        .i_data  (i_wdata[`FCS_STS2_LINE3_RST]),
        .i_lock  (freeze_reg),
        .o_value (line3_rst)
    );

    fcs_susp_flag u_ers_susp (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_suspended (i_erase_susp),
        .o_flag      (erase_susp)
    );

    fcs_susp_flag u_pgm_susp (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_suspended (i_prog_susp),
        .o_flag      (prog_susp)
    );

    // uniform-only parts ignore the parameter location
    wire parm_top = parm_top_raw && !i_uniform_part;

    // writable non-volatile and volatile fields
    assign latency_next = wr_cfg ? i_wdata[`FCS_CFG_LAT_HI:`FCS_CFG_LAT_LO] : latency_reg;
    assign quad_next    = wr_cfg ? i_wdata[`FCS_CFG_QUAD] : quad_reg;
    assign freeze_next  = wr_cfg ? i_wdata[`FCS_CFG_FREEZE] : freeze_reg;
    // protection bits locked while frozen
    assign bp_next      = (wr_bprot && !freeze_reg) ? i_wdata[2:0] : bp_reg;

    // register images
    wire [7:0] cfg_image  = {latency_reg, prot_bot, rsvd4, bp_vol, parm_top_raw,
                             quad_reg, freeze_reg};
    wire [7:0] sts2_image = {big_erase, page_wrap, line3_rst, 3'h0,
                             erase_susp, prog_susp};
    wire [7:0] bp_image   = {5'h00, bp_reg};
    wire [7:0] strap_image = {7'h00, i_uniform_part};
    wire [7:0] cfg_reset   = `FCS_CFG_RESET;

    always_comb begin
        if (!i_rd) begin
            rdata_next = 8'h00;
        end else if (i_addr == `FCS_ADDR_CFG) begin
            rdata_next = cfg_image;
        end else if (i_addr == `FCS_ADDR_STS2) begin
            rdata_next = sts2_image;
        end else if (i_addr == `FCS_ADDR_BPROT) begin
            rdata_next = bp_image;
        end else begin
            rdata_next = strap_image;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            latency_reg <= cfg_reset[`FCS_CFG_LAT_HI:`FCS_CFG_LAT_LO];
            quad_reg    <= 1'b0;
            freeze_reg  <= 1'b0;
            rdata_reg   <= 8'h00;
        end else begin
            latency_reg <= latency_next;
            quad_reg    <= quad_next;
            freeze_reg  <= freeze_next;
            rdata_reg   <= rdata_next;
        end
    end

    // volatile protection reset value picked up after release
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bp_reg         <= `FCS_BP_RESET_NV;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            bp_reg         <= bp_vol ? `FCS_BP_RESET_VOL : `FCS_BP_RESET_NV;
            strap_done_reg <= 1'b1;
        end else begin
            bp_reg         <= bp_next;
        end
    end

    // outputs from flops
    wire [8:0]   erase_kb  = big_erase ? `FCS_ERASE_BIG_KB : `FCS_ERASE_SMALL_KB;
    wire fcs_io_mode_t io_next = quad_reg ? FCS_IO_QUAD : FCS_IO_DUAL;
    wire fcs_line3_t l3_next = line3_rst ? FCS_LINE3_RESET : FCS_LINE3_HOLD;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            latency_out_reg  <= 2'h0;
            prot_bot_out_reg <= 1'b0;
            bp_out_reg       <= 3'h0;
            bp_vol_out_reg   <= 1'b0;
            parm_top_out_reg <= 1'b0;
            io_mode_reg      <= FCS_IO_DUAL;
            frozen_out_reg   <= 1'b0;
            erase_kb_reg     <= `FCS_ERASE_SMALL_KB;
            wrap_out_reg     <= 1'b0;
            line3_reg        <= FCS_LINE3_HOLD;
        end else begin
            latency_out_reg  <= latency_reg;
            prot_bot_out_reg <= prot_bot;
            bp_out_reg       <= bp_reg;
            bp_vol_out_reg   <= bp_vol;
            parm_top_out_reg <= parm_top;
            io_mode_reg      <= io_next;
            frozen_out_reg   <= freeze_reg;
            erase_kb_reg     <= erase_kb;
            wrap_out_reg     <= page_wrap;
            line3_reg        <= l3_next;
        end
    end

    assign o_rdata                 = rdata_reg;
    assign o_latency_code          = latency_out_reg;
    assign o_protect_from_bottom   = prot_bot_out_reg;
    assign o_block_protect_bits    = bp_out_reg;
    assign o_protect_bits_volatile = bp_vol_out_reg;
    assign o_param_sectors_top     = parm_top_out_reg;
    assign o_io_mode               = io_mode_reg;
    assign o_frozen                = frozen_out_reg;
    assign o_erase_size_kb         = erase_kb_reg;
    assign o_page_wrap_size        = wrap_out_reg;
    assign o_line3_function        = line3_reg;
endmodule : fcs_config_status

/* fcs_config_status_checker.sv */
// port assertions for the flash config/status register block
`timescale 1ns/1ps
module fcs_config_status_checker (
    // clock and reset
    input logic                  i_clock,
    input logic                  i_rst,
    // register port
    input logic [1:0]            i_addr,
    input logic [7:0]            i_wdata,
    input logic                  i_wr,
    input logic                  i_rd,
    input logic [7:0]            o_rdata,
    // array state
    input logic                  i_erase_susp,
    input logic                  i_prog_susp,
    input logic                  i_uniform_part,
    // outputs
    input logic [1:0]            o_latency_code,
    input logic [2:0]            o_block_protect_bits,
    input logic                  o_protect_from_bottom,
    input logic                  o_param_sectors_top,
    input fcs_pkg::fcs_io_mode_t o_io_mode,
    input logic                  o_frozen,
    input logic [8:0]            o_erase_size_kb,
    input fcs_pkg::fcs_line3_t   o_line3_function
);
    import fcs_pkg::*;
    logic [1:0] susp;
    assign susp = {i_erase_susp, i_prog_susp};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // write, then the freeze state that decided it, seen one cycle later
    sequence unlocked_wr(a, b);
        i_wr && i_addr == a && b ##1 !o_frozen;
    endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_latency_wr: assert property (i_wr && i_addr == 2'h0 |-> ##2 o_latency_code == $past(i_wdata[7:6], 2))
        else $error("latency code does not follow write");
    a_quad_wr: assert property (i_wr && i_addr == 2'h0 |-> ##2 o_io_mode == ($past(i_wdata[1], 2) ? FCS_IO_QUAD : FCS_IO_DUAL))
        else $error("io mode does not follow write");
    a_bp_frozen: assert property (i_wr && i_addr == 2'h2 ##1 o_frozen |=> $stable(o_block_protect_bits) [*2])
        else $error("protect bits changed while frozen");
    a_erase_big: assert property (unlocked_wr(2'h1, i_wdata[7]) |=> o_erase_size_kb == 9'h100)
        else $error("erase size not 256k");
    a_line3_reset: assert property (unlocked_wr(2'h1, i_wdata[5]) |=> o_line3_function == FCS_LINE3_RESET)
        else $error("line 3 not reset function");
    a_prot_sticky: assert property (o_protect_from_bottom |=> o_protect_from_bottom)
        else $error("protect start returned to default");
    a_param_uniform: assert property (i_uniform_part [*3] |-> !o_param_sectors_top)
        else $error("parameter bit active on uniform part");
    a_susp_flags: assert property ($past(i_rd) && $past(i_addr) == 2'h1 && $past(susp, 2) == $past(susp, 3) |-> o_rdata[1:0] == $past(susp, 2))
        else $error("suspend flags wrong");
    a_rsvd_zero: assert property ($past(i_rd) && $past(i_addr) == 2'h1 |-> o_rdata[4:2] == 3'h0)
        else $error("reserved status bits not zero");
endmodule : fcs_config_status_checker

bind fcs_config_status fcs_config_status_checker chk_u (.i_clock, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_erase_susp, .i_prog_susp, .i_uniform_part, .o_latency_code,
    .o_block_protect_bits, .o_protect_from_bottom, .o_param_sectors_top, .o_io_mode,
    .o_frozen, .o_erase_size_kb, .o_line3_function);

/* fcs_config_status_tb.sv */
// self-checking bench for the flash config/status register block
`timescale 1ns/1ps
module fcs_config_status_tb;
    import fcs_pkg::*;
    logic         i_clock, i_rst, wr, rd, esus, psus, unif, bot, vol, ptop, frz, wrap;
    logic [1:0]   addr, lat;
    logic [2:0]   bp;
    logic [7:0]   wdata, rdata;
    logic [8:0]   esize;
    fcs_io_mode_t io;
    fcs_line3_t   l3;
    int           n_errors = 0;
    int           checked = 0;

    fcs_host_model host_u (.i_clock(i_clock), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .i_rdata(rdata));
    fcs_config_status dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_erase_susp(esus),
        .i_prog_susp(psus), .i_uniform_part(unif), .o_latency_code(lat),
        .o_protect_from_bottom(bot), .o_block_protect_bits(bp),
        .o_protect_bits_volatile(vol), .o_param_sectors_top(ptop), .o_io_mode(io),
        .o_frozen(frz), .o_erase_size_kb(esize), .o_page_wrap_size(wrap),
        .o_line3_function(l3));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk({1'b0, d}, {1'b0, exp});
    endtask : rdc
    task automatic settle();
        repeat (3) @(posedge i_clock);
        #1;
    endtask : settle
    task automatic do_reset();
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
    endtask : do_reset
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic t_defaults();
        rdc(2'h0, 8'h00);
        rdc(2'h1, 8'h00);
        rdc(2'h2, 8'h00);
        chk(io, FCS_IO_DUAL);
        chk(esize, 9'h040);
        chk(l3, FCS_LINE3_HOLD);
    endtask : t_defaults
    task automatic t_latency_quad();
        for (int i = 0; i < 4; i++) begin
            host_u.wr(2'h0, {i[1:0], 4'h0, i[0], 1'b0});
            settle();
            chk(lat, i[1:0]);
            chk(io, i[0] ? FCS_IO_QUAD : FCS_IO_DUAL);
        end
        rdc(2'h0, 8'hC2);
    endtask : t_latency_quad
    task automatic t_suspend();
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clock);
            {esus, psus} <= i[1:0];
            settle();
            rdc(2'h1, {6'h00, i[1:0]});
        end
        @(posedge i_clock);
        {esus, psus} <= 2'h0;
    endtask : t_suspend
    task automatic t_otp();
        host_u.wr(2'h1, 8'hFF);
        settle();
        rdc(2'h1, 8'hE0);
        chk(esize, 9'h100);
        chk(l3, FCS_LINE3_RESET);
        chk(wrap, 1'b1);
        host_u.wr(2'h1, 8'h00);
        rdc(2'h1, 8'hE0);
        host_u.wr(2'h0, 8'h2C);
        settle();
        chk({bot, vol, ptop}, 3'h7);
        @(posedge i_clock);
        unif <= 1'b1;
        settle();
        chk(ptop, 1'b0);
        @(posedge i_clock);
        unif <= 1'b0;
        host_u.wr(2'h0, 8'h00);
        rdc(2'h0, 8'h2C);
    endtask : t_otp
    task automatic t_freeze();
        host_u.wr(2'h2, 8'h05);
        settle();
        chk(bp, 3'h5);
        host_u.wr(2'h0, 8'h21);
        settle();
        chk(frz, 1'b1);
        host_u.wr(2'h2, 8'h02);
        settle();
        chk(bp, 3'h5);
        host_u.wr(2'h0, 8'h35);
        rdc(2'h0, 8'h2D);
        host_u.wr(2'h0, 8'h2C);
        settle();
        host_u.wr(2'h2, 8'h02);
        settle();
        chk(bp, 3'h2);
        host_u.wr(2'h3, 8'hFF);
        rdc(2'h3, 8'h00);
    endtask : t_freeze

    initial begin
        i_rst = 1'b1;
        esus = 1'b0;
        psus = 1'b0;
        unif = 1'b0;
        do_reset();
        t_defaults();
        t_latency_quad();
        t_suspend();
        t_otp();
        t_freeze();
        do_reset();
        rdc(2'h0, 8'h00);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        end_of_test();
    end
endmodule : fcs_config_status_tb

/* fcs_host_model.sv */
// host controller model driving the register port
`timescale 1ns/1ps
module fcs_host_model (
    // clock
    input  logic       i_clock,
    // register port
    output logic [1:0] o_addr,
    output logic [7:0] o_wdata,
    output logic       o_wr,
    output logic       o_rd,
    input  logic [7:0] i_rdata
);
    initial begin
        o_addr = 2'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        // released data must not keep its last value
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clock);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd
endmodule : fcs_host_model

/* fcs_otp_bit.sv */
// one-time-programmable bit: leaves its default once, freeze can block the change
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_otp_bit (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // write side
    input  wire logic i_wr,
    input  wire logic i_data,
    input  wire logic i_lock,
    // state
    output logic      o_value
);
    logic value_reg;
    logic value_next;

    // only a move away from default is taken
    assign value_next = (i_wr && !i_lock && (i_data != `FCS_OTP_DEFAULT)) ? i_data : value_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            value_reg <= `FCS_OTP_DEFAULT;
        end else begin
            value_reg <= value_next;
        end
    end

    assign o_value = value_reg;
endmodule : fcs_otp_bit

/* fcs_pkg.sv */
// types shared by the flash config/status register block
package fcs_pkg;
    typedef enum logic [1:0] {
        FCS_IO_SINGLE = 2'b00,
        FCS_IO_DUAL   = 2'b01,
        FCS_IO_QUAD   = 2'b10
    } fcs_io_mode_t;

    typedef enum logic [0:0] {
        FCS_LINE3_HOLD  = 1'b0,
        FCS_LINE3_RESET = 1'b1
    } fcs_line3_t;
endpackage : fcs_pkg

/* fcs_regs.svh */
// offsets, field positions, reset values and sizes for the flash config/status registers
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

`define FCS_ADDR_CFG        2'h0
`define FCS_ADDR_STS2       2'h1
`define FCS_ADDR_BPROT      2'h2
`define FCS_ADDR_STRAP      2'h3

`define FCS_CFG_LAT_HI      7
`define FCS_CFG_LAT_LO      6
`define FCS_CFG_PROT_BOT    5
`define FCS_CFG_RSVD4       4
`define FCS_CFG_BP_VOL      3
`define FCS_CFG_PARM_TOP    2
`define FCS_CFG_QUAD        1
`define FCS_CFG_FREEZE      0

`define FCS_STS2_BIG_ERASE  7
`define FCS_STS2_PAGE_WRAP  6
`define FCS_STS2_LINE3_RST  5
`define FCS_STS2_ERS_SUSP   1
`define FCS_STS2_PGM_SUSP   0

`define FCS_CFG_RESET       8'h00
`define FCS_STS2_RESET      8'h00
`define FCS_BP_RESET_VOL    3'h7
`define FCS_BP_RESET_NV     3'h0
`define FCS_OTP_DEFAULT     1'h0

`define FCS_ERASE_BIG_KB    9'h100
`define FCS_ERASE_SMALL_KB  9'h040
`define FCS_PARM_SECTOR_KB  9'h004

`endif

/* fcs_susp_flag.sv */
// volatile read-only suspend flag, follows the array controller state
`timescale 1ns/1ps
module fcs_susp_flag (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // suspend level from the array controller
    input  wire logic i_suspended,
    // flag
    output logic      o_flag
);
    logic flag_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= i_suspended;
        end
    end

    assign o_flag = flag_reg;
endmodule : fcs_susp_flag
